// [include/icv_pkg.sv]
// package: host-side controller constants for the image convolver setup port
package icv_pkg;
    // own command registers, word offsets on the plain software port
    localparam logic [3:0] REG_CMD      = 4'h0;
    localparam logic [3:0] REG_ADDR     = 4'h1;
    localparam logic [3:0] REG_WDATA    = 4'h2;
    localparam logic [3:0] REG_STATUS   = 4'h3;
    localparam logic [3:0] REG_RDATA    = 4'h4;
    localparam logic [3:0] REG_PINS     = 4'h5;
    localparam logic [3:0] REG_SETUP    = 4'h6;
    // command field positions
    localparam int CMD_GO_BIT   = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CMD_LOAD_BIT = 2;
    // pins register field positions
    localparam int PIN_BYPASS_BIT  = 0;
    localparam int PIN_FIELD_BIT   = 1;
    localparam int PIN_INTERL_BIT  = 2;
    localparam int PIN_SOLE_BIT    = 3;
    localparam int PIN_ROUTE_BIT   = 4;
    // device register indices
    localparam logic [7:0] DEV_REG_A = 8'h00;
    localparam logic [7:0] DEV_REG_B = 8'h01;
    localparam logic [7:0] DEV_REG_C = 8'h02;
    localparam logic [7:0] DEV_REG_D = 8'h03;
    // device field positions
    localparam int A_MODE_LSB  = 4;
    localparam int A_MODE_W    = 3;
    localparam int B_LEN_LSB   = 1;
    localparam int B_LEN_W     = 2;
    localparam int B_XDLY_BIT  = 3;
    localparam int C_SLICE_LSB = 4;
    localparam int C_SLICE_W   = 2;
    localparam int D_PIXDLY_LSB = 2;
    localparam int D_PIXDLY_W   = 3;
    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [4:0]  RST_PINS = 5'h01;
    // strobe timing: strobe must outlast the strobe to reply delay
    localparam int STROBE_REPLY_NS = 50;
    localparam int CLK_PERIOD_NS   = 4;
    localparam int STROBE_CYC = (STROBE_REPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int RECOVER_CYC = 2;
    localparam int CNT_W = 8;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RECOVER
    } icv_state_e;
endpackage

// [design/icv_sync.sv]
// three-stage pin synchroniser with agreement filter
module icv_sync #(
    parameter int W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // stage one feeds stage two only; output moves once stages two and three agree
    always_ff @(posedge clk) begin
        if (srst) begin
            dout <= RST;
        end else if (s2_r == s3_r) begin
            dout <= s3_r;
        end
    end
endmodule

// [design/icv_host.sv]
// host controller that loads and reads back the convolver setup registers
// Contract
// [RL1] register A bits 6:4 choose window mode
// [RL2] unused window coefficients written as zero
// [RL3] device ignores A bits 3:0, bit 7
// [RL4] register C bits 5:4 pick slice
// [RL5] device shows top 16 bits, overflow
// [RL6] register B bits 2:1 line length, bit 3
// [RL7] sole device: clear register D bits 4:2
// [RL8] delayed timing pipeline matches window size
// [RL9] sole and host-mode selects held low; the host sets them from pins register bits 3 and 4, both low after reset
// [RL10] load pin is output during EPROM load
// [RL11] non-interlaced: drive bypass high
// [RL12] interlaced: bypass marks odd or even field
// [RL13] chip enable starts a coefficient reload
// [RL14] prior field on prior input, live on live
// [RL15] extended precision splits pixel over inputs
// [RL16] host mode needs strobe and read/write line
// [RL17] host data lines are two-way
// [RL18] strobe outlasts reply delay, reply ignored
// [RL19] load pin and chip enable share decode
// [RL20] device shift option scales sum by 256
// [RL21] above 20MHz precision limited to 16 bits
// [RL22] 16-bit modes lack last line delay output
// [RL23] register D bit 0 delays expansion input
// [RL24] register D bit 4 signed pixels
// [RL25] device registers data on pixel clock
module icv_host (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [3:0] sw_addr,
    input  wire logic [7:0] sw_wdata,
    input  wire logic       sw_wr,
    input  wire logic       sw_rd,
    output logic      [7:0] sw_rdata,
    output logic [7:0] dev_addr,
    output logic [7:0] host_data_lines_o,
    output logic [7:0] host_data_lines_oe_n,
    input  wire logic [7:0] host_data_lines_i,
    output logic       host_strobe_n,
    output logic       rd_wr_n,
    output logic       load_cycle_pin_n,
    output logic       chip_enable_n,
    output logic       host_mode_select,
    output logic       sole_select_n,
    output logic       bypass,
    input  wire logic  reply_out_n
);
    logic [7:0]  addr_r;
    logic [7:0]  wdata_r;
    logic [7:0]  rdata_r;
    logic [4:0]  pins_r;
    logic        read_r;
    logic        load_r;
    logic        busy_r;
    logic        done_r;
    logic        setup_err_r;
    logic [7:0]  setup_r;
    logic [icv_pkg::CNT_W-1:0] cnt_r;
    icv_pkg::icv_state_e state_r;
    logic [7:0]  data_sync;
    logic        reply_sync;
    logic        go;
    logic [7:0]  masked_wdata;

    // host data lines pass the pin synchroniser before being captured
    icv_sync #(.W(8), .RST(8'h00)) u_sync (
        .clk  (clk),
        .srst (srst),
        .din  (host_data_lines_i),
        .dout (data_sync)
    );

    // reply is a pin from the device, so it is synchronised like the data lines
    icv_sync #(.W(1), .RST(1'b1)) u_sync_reply (
        .clk  (clk),
        .srst (srst),
        .din  (reply_out_n),
        .dout (reply_sync)
    );

    assign go = sw_wr && (sw_addr == icv_pkg::REG_CMD) && sw_wdata[icv_pkg::CMD_GO_BIT]
                && !busy_r;

    // software-side registers
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_r  <= icv_pkg::RST_BYTE;
            wdata_r <= icv_pkg::RST_BYTE;
            pins_r  <= icv_pkg::RST_PINS;
            setup_r <= icv_pkg::RST_BYTE;
            read_r  <= 1'b0;
            load_r  <= 1'b0;
        end else if (sw_wr) begin
            case (sw_addr)
                icv_pkg::REG_ADDR:  addr_r  <= sw_wdata;
                icv_pkg::REG_WDATA: wdata_r <= sw_wdata;
                icv_pkg::REG_PINS:  pins_r  <= sw_wdata[4:0];
                icv_pkg::REG_SETUP: setup_r <= sw_wdata;
                icv_pkg::REG_CMD: begin
                    if (!busy_r) begin
                        read_r <= sw_wdata[icv_pkg::CMD_READ_BIT];
                        load_r <= sw_wdata[icv_pkg::CMD_LOAD_BIT];
                    end
                end
                default: ;
            endcase
        end
    end

    // sole-device writes: zero register D pixel delay; writes to other registers pass unchanged
    always_comb begin
        masked_wdata = wdata_r;
        if (pins_r[icv_pkg::PIN_SOLE_BIT] && addr_r == icv_pkg::DEV_REG_D) begin
            masked_wdata[icv_pkg::D_PIXDLY_LSB +: icv_pkg::D_PIXDLY_W] = 3'h0; // [RL7]
        end
    end

    // sequencer: strobe held long enough that the reply can be ignored
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= icv_pkg::ST_IDLE;
            cnt_r   <= '0;
            busy_r  <= 1'b0;
        end else begin
            case (state_r)
                icv_pkg::ST_IDLE: begin
                    if (go) begin
                        state_r <= icv_pkg::ST_SETUP;
                        busy_r  <= 1'b1;
                    end
                end
                icv_pkg::ST_SETUP: begin
                    state_r <= icv_pkg::ST_STROBE;
                    cnt_r   <= icv_pkg::CNT_W'(icv_pkg::STROBE_CYC - 1);
                end
                icv_pkg::ST_STROBE: begin
                    if (cnt_r == '0) begin
                        state_r <= icv_pkg::ST_HOLD; // [RL18]
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                icv_pkg::ST_HOLD: begin
                    state_r <= icv_pkg::ST_RECOVER;
                    cnt_r   <= icv_pkg::CNT_W'(icv_pkg::RECOVER_CYC - 1);
                end
                icv_pkg::ST_RECOVER: begin
                    if (cnt_r == '0) begin
                        state_r <= icv_pkg::ST_IDLE;
                        busy_r  <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: state_r <= icv_pkg::ST_IDLE;
            endcase
        end
    end

    // done flag: set wins over software clear by read of status
    always_ff @(posedge clk) begin
        if (srst) begin
            done_r <= 1'b0;
        end else if (state_r == icv_pkg::ST_HOLD) begin
            done_r <= 1'b1;
        end else if (sw_rd && sw_addr == icv_pkg::REG_STATUS) begin
            done_r <= 1'b0;
        end
    end

    // read data captured at end of strobe, before it is withdrawn
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= icv_pkg::RST_BYTE;
        end else if (state_r == icv_pkg::ST_HOLD && read_r) begin
            rdata_r <= data_sync; // [RL17]
        end
    end

    // flag a host setup that breaks sole-device pin or mode limits
    always_ff @(posedge clk) begin
        if (srst) begin
            setup_err_r <= 1'b0;
        end else begin
            // extended precision cannot run interlaced on one device
            setup_err_r <= pins_r[icv_pkg::PIN_SOLE_BIT] && pins_r[icv_pkg::PIN_INTERL_BIT]
                           && setup_r[3]; // [RL14] [RL15]
        end
    end

    // pin drivers, all from flip-flops
    always_ff @(posedge clk) begin
        if (srst) begin
            dev_addr             <= icv_pkg::RST_BYTE;
            host_data_lines_o    <= icv_pkg::RST_BYTE;
            host_data_lines_oe_n <= 8'hff;
            host_strobe_n        <= 1'b1;
            rd_wr_n              <= 1'b1;
            load_cycle_pin_n     <= 1'b1;
            chip_enable_n        <= 1'b1;
        end else begin
            // address and data frozen for a whole transfer, whatever software writes meanwhile
            if (!busy_r) begin
                dev_addr          <= addr_r;
                host_data_lines_o <= masked_wdata; // [RL1] [RL2] [RL4] [RL6] [RL8]
            end
            rd_wr_n           <= busy_r ? read_r : 1'b1; // [RL16]
            // drive the lines only for writes, release for reads
            host_data_lines_oe_n <= (busy_r && !read_r) ? 8'h00 : 8'hff; // [RL17]
            host_strobe_n     <= !(state_r == icv_pkg::ST_STROBE); // [RL16]
            // load pin and chip enable from one decode
            load_cycle_pin_n  <= !(busy_r && load_r); // [RL19]
            chip_enable_n     <= !(busy_r && load_r); // [RL13] [RL19]
        end
    end

    // mode and field pins
    always_ff @(posedge clk) begin
        if (srst) begin
            host_mode_select <= 1'b1;
            sole_select_n    <= 1'b1;
            bypass           <= 1'b1;
        end else begin
            host_mode_select <= pins_r[icv_pkg::PIN_ROUTE_BIT]; // [RL9] [RL16]
            sole_select_n    <= !pins_r[icv_pkg::PIN_SOLE_BIT]; // [RL9]
            // non-interlaced forces bypass high; interlaced carries field parity
            bypass <= pins_r[icv_pkg::PIN_INTERL_BIT] ? pins_r[icv_pkg::PIN_FIELD_BIT]
                                                     : 1'b1; // [RL11] [RL12]
        end
    end

    // software read port, data one cycle later; unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            sw_rdata <= icv_pkg::RST_BYTE;
        end else if (sw_rd) begin
            case (sw_addr)
                icv_pkg::REG_ADDR:   sw_rdata <= addr_r;
                icv_pkg::REG_WDATA:  sw_rdata <= wdata_r;
                icv_pkg::REG_STATUS: sw_rdata <= {4'h0, !reply_sync, setup_err_r,
                                                  done_r, busy_r};
                icv_pkg::REG_RDATA:  sw_rdata <= rdata_r;
                icv_pkg::REG_PINS:   sw_rdata <= {3'h0, pins_r};
                icv_pkg::REG_SETUP:  sw_rdata <= setup_r;
                icv_pkg::REG_CMD:    sw_rdata <= {5'h0, load_r, read_r, 1'b0};
                default:             sw_rdata <= icv_pkg::RST_BYTE;
            endcase
        end else begin
            sw_rdata <= icv_pkg::RST_BYTE;
        end
    end
endmodule

// [tb/icv_host_sva.sv]
// checker: port-level properties of the setup host controller
module icv_host_sva (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic       sw_wr,
    input wire logic [7:0] dev_addr,
    input wire logic [7:0] host_data_lines_oe_n,
    input wire logic       host_strobe_n,
    input wire logic       rd_wr_n,
    input wire logic       load_cycle_pin_n,
    input wire logic       chip_enable_n,
    input wire logic       sole_select_n,
    input wire logic       bypass
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] pins_r;
    logic [1:0] qcnt_r;
    logic [7:0] low_r;
    logic       pw;
    assign pw = sw_wr && sw_addr == icv_pkg::REG_PINS;
    // shadow of the pins register, so pin levels can be predicted
    always_ff @(posedge clk) begin
        if (srst) pins_r <= icv_pkg::RST_PINS;
        else if (pw) pins_r <= sw_wdata[4:0];
    end
    // settle count: pins are registered twice before they reach the pads
    always_ff @(posedge clk) begin
        if (srst || pw) qcnt_r <= 2'h0;
        else if (qcnt_r != 2'h3) qcnt_r <= qcnt_r + 2'h1;
    end
    always_ff @(posedge clk) begin
        if (srst || host_strobe_n) low_r <= 8'h00;
        else low_r <= low_r + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_wr_drive; !host_strobe_n && !rd_wr_n |-> host_data_lines_oe_n == 8'h00; endproperty
    property p_rd_rel; !host_strobe_n && rd_wr_n |-> host_data_lines_oe_n == 8'hff; endproperty
    property p_len; $rose(host_strobe_n) |-> low_r == 8'(icv_pkg::STROBE_CYC); endproperty
    property p_rec; $rose(host_strobe_n) |-> host_strobe_n [*3]; endproperty
    property p_hold;
        !host_strobe_n && $past(!host_strobe_n) |-> $stable(dev_addr) && $stable(rd_wr_n);
    endproperty
    property p_ldce; load_cycle_pin_n == chip_enable_n; endproperty
    property p_sole; qcnt_r == 2'h3 |-> sole_select_n == !pins_r[3]; endproperty
    property p_byp; qcnt_r == 2'h3 && !pins_r[2] |-> bypass; endproperty
    property p_field; qcnt_r == 2'h3 && pins_r[2] |-> bypass == pins_r[1]; endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("lines idle in write");
    a_rd_rel: assert property (p_rd_rel) else $error("lines driven in read");
    a_len: assert property (p_len) else $error("strobe width wrong");
    a_rec: assert property (p_rec) else $error("strobe gap short");
    a_hold: assert property (p_hold) else $error("address moved in strobe");
    a_ldce: assert property (p_ldce) else $error("load and enable differ");
    a_sole: assert property (p_sole) else $error("sole select wrong");
    a_byp: assert property (p_byp) else $error("bypass low");
    a_field: assert property (p_field) else $error("bypass not field");
    c_rd: cover property (!host_strobe_n && rd_wr_n);
    c_wr: cover property (!host_strobe_n && !rd_wr_n);
    c_il: cover property (qcnt_r == 2'h3 && pins_r[2]);
endmodule
bind icv_host icv_host_sva icv_host_sva_inst (.clk(clk), .srst(srst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .dev_addr(dev_addr),
    .host_data_lines_oe_n(host_data_lines_oe_n), .host_strobe_n(host_strobe_n),
    .rd_wr_n(rd_wr_n), .load_cycle_pin_n(load_cycle_pin_n), .chip_enable_n(chip_enable_n),
    .sole_select_n(sole_select_n), .bypass(bypass));

// [tb/icv_dev_model.sv]
// device model: setup registers, two-way data lines, reply
module icv_dev_model #(parameter int REPLY_DLY = 3) (
    input wire logic       clk,
    input wire logic [7:0] dev_addr,
    input wire logic [7:0] hd_o,
    input wire logic [7:0] hd_oe_n,
    input wire logic       strobe_n,
    input wire logic       rd_wr_n,
    output logic     [7:0] hd_bus,
    output logic           reply_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [4];
    logic [7:0] last_r;
    logic [7:0] cnt_r;
    logic       dev_en;
    // pixel path, gain and prom load are not modelled here
    assign dev_en = !strobe_n && rd_wr_n;
    // released lines show the inverse of the last level, no pull-ups
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            hd_bus[i] = !hd_oe_n[i] ? hd_o[i] : (dev_en ? regs[dev_addr[1:0]][i] : ~last_r[i]);
        end
    end
    always_ff @(posedge clk) begin
        last_r <= hd_bus;
        if (!strobe_n && !rd_wr_n) regs[dev_addr[1:0]] <= hd_bus;
    end
    always_ff @(posedge clk) begin
        if (strobe_n) cnt_r <= 8'h00;
        else if (cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
    end
    assign reply_n = !(cnt_r >= 8'(REPLY_DLY));
endmodule

// [tb/icv_host_tb.sv]
// testbench for the setup host controller
module icv_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] ix; logic [7:0] d; logic [7:0] e;} icv_row_s;
    logic clk, srst, sw_wr, sw_rd, strobe_n, rd_wr_n, load_n, ce_n, hmode, sole_n, byp, rep_n;
    logic [3:0] sw_addr;
    logic [7:0] sw_wdata, sw_rdata, dev_addr, hd_o, hd_oe_n, hd_bus, v;
    int         n_fail, num_checks, n_falls;
    icv_row_s   rows [6];
    initial begin clk = 1'b0; forever #2 clk = ~clk; end
    always @(negedge strobe_n) n_falls++;
    icv_host icv_host_inst (.clk(clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr),
        .host_data_lines_o(hd_o), .host_data_lines_oe_n(hd_oe_n), .host_data_lines_i(hd_bus),
        .host_strobe_n(strobe_n), .rd_wr_n(rd_wr_n), .load_cycle_pin_n(load_n),
        .chip_enable_n(ce_n), .host_mode_select(hmode), .sole_select_n(sole_n),
        .bypass(byp), .reply_out_n(rep_n));
    icv_dev_model icv_dev_model_inst (.clk(clk), .dev_addr(dev_addr), .hd_o(hd_o),
        .hd_oe_n(hd_oe_n), .strobe_n(strobe_n), .rd_wr_n(rd_wr_n), .hd_bus(hd_bus),
        .reply_n(rep_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk); sw_addr <= a; sw_wdata <= d; sw_wr <= 1'b1;
        @(posedge clk); sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk); sw_addr <= a; sw_rd <= 1'b1;
        @(posedge clk); sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    // polls done with a bound; a missing done counts as a mismatch
    task automatic dev_op(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] s;
        s = 8'h00;
        wr(icv_pkg::REG_ADDR, a);
        wr(icv_pkg::REG_WDATA, d);
        wr(icv_pkg::REG_CMD, cmd);
        for (int i = 0; i < 40 && s[1] !== 1'b1; i++) rd(icv_pkg::REG_STATUS, s);
        if (s[1] !== 1'b1) chk(s, 8'h02);
    endtask
    task automatic pins(input logic [7:0] p, input logic [7:0] e);
        wr(icv_pkg::REG_PINS, p);
        repeat (4) @(posedge clk);
        #1 chk({5'h0, hmode, sole_n, byp}, e);
    endtask
    task automatic finish_test;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #50us;
        n_fail++;
        $display("watchdog expired");
        finish_test();
    end
    initial begin
        srst = 1'b1; sw_wr = 1'b0; sw_rd = 1'b0; sw_addr = 4'h0; sw_wdata = 8'h00;
        n_fail = 0; num_checks = 0;
        rows[0] = '{icv_pkg::DEV_REG_A, 8'h70, 8'h70};
        rows[1] = '{icv_pkg::DEV_REG_A, 8'h8f, 8'h8f};
        rows[2] = '{icv_pkg::DEV_REG_B, 8'h0e, 8'h0e};
        rows[3] = '{icv_pkg::DEV_REG_C, 8'h10, 8'h10};
        rows[4] = '{icv_pkg::DEV_REG_C, 8'h20, 8'h20};
        rows[5] = '{icv_pkg::DEV_REG_D, 8'h1f, 8'h1f};
        repeat (8) @(posedge clk);
        #1 chk({6'h0, strobe_n, byp}, 8'h03);
        chk(hd_oe_n, 8'hff);
        @(posedge clk) srst <= 1'b0;
        $display("reset test done");
        pins(8'h10, 8'h07);
        foreach (rows[k]) begin
            dev_op(8'h05, rows[k].ix, rows[k].d);
            dev_op(8'h03, rows[k].ix, 8'h00);
            rd(icv_pkg::REG_RDATA, v);
            chk(v, rows[k].e);
        end
        $display("table test done");
        pins(8'h18, 8'h05);
        dev_op(8'h01, icv_pkg::DEV_REG_D, 8'h1d);
        dev_op(8'h03, icv_pkg::DEV_REG_D, 8'h00);
        rd(icv_pkg::REG_RDATA, v);
        chk(v, 8'h01);
        // sole device with interlace and extended precision must raise the setup error
        pins(8'h1c, 8'h04);
        wr(icv_pkg::REG_SETUP, 8'h08);
        rd(icv_pkg::REG_STATUS, v);
        chk(v & 8'h04, 8'h04);
        $display("sole test done");
        pins(8'h16, 8'h07);
        pins(8'h14, 8'h06);
        pins(8'h10, 8'h07);
        wr(4'hf, 8'hff);
        rd(icv_pkg::REG_PINS, v);
        chk(v, 8'h10);
        $display("pins test done");
        n_falls = 0;
        wr(icv_pkg::REG_CMD, 8'h05);
        repeat (3) @(posedge clk);
        #1 chk({6'h0, ce_n, load_n}, 8'h00);
        dev_op(8'h01, icv_pkg::DEV_REG_B, 8'h0e);
        repeat (30) @(posedge clk);
        chk(8'(n_falls), 8'h01);
        $display("busy test done");
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({5'h0, hmode, sole_n, byp}, 8'h07);
        @(posedge clk) srst <= 1'b0;
        rd(icv_pkg::REG_PINS, v);
        chk(v, 8'h01);
        $display("second reset test done");
        finish_test();
    end
endmodule
